// File: include/mpsc_pkg.sv
// Constants and types shared by the memory power state control block
package mpsc_pkg;

    // Register byte offsets behind the hub register base
    localparam logic [11:0] MPSC_OFF_DLLPD  = 12'hF0C;
    localparam logic [11:0] MPSC_OFF_POWER_MANAGEMENT_CONFIGURATION  = 12'hF10;
    localparam logic [11:0] MPSC_OFF_SRSTAT = 12'hF14;

    // Reset values
    localparam logic [15:0] MPSC_RST_DLLPD  = 16'h0000;
    localparam logic [31:0] MPSC_RST_POWER_MANAGEMENT_CONFIGURATION  = 32'h00000000;
    localparam logic [1:0]  MPSC_RST_SRSTAT = 2'h0;

    // Writable bits; everything else reads as zero
    localparam logic [15:0] MPSC_WMASK_DLLPD = 16'h607F;
    localparam logic [31:0] MPSC_WMASK_POWER_MANAGEMENT_CONFIGURATION = 32'hC000001F;

    // Master DLL power-down C-state dependency field
    localparam int          MPSC_DEP_LSB   = 4;
    localparam int          MPSC_DEP_MSB   = 6;
    localparam logic [2:0]  MPSC_DEP_NEVER = 3'h0;
    localparam logic [2:0]  MPSC_DEP_C3C4  = 3'h6;

    // Power management configuration fields
    localparam int          MPSC_EN_BIT    = 4;
    localparam int          MPSC_SNOOP_BIT = 3;
    localparam int          MPSC_MODE_LSB  = 0;
    localparam int          MPSC_MODE_MSB  = 1;
    localparam logic [1:0]  MPSC_MODE_ALL  = 2'h0;
    localparam logic [1:0]  MPSC_MODE_C2   = 2'h1;
    localparam logic [1:0]  MPSC_MODE_C3   = 2'h2;

    // Processor C-state codes
    localparam logic [2:0]  MPSC_C0 = 3'h0;
    localparam logic [2:0]  MPSC_C2 = 3'h2;
    localparam logic [2:0]  MPSC_C3 = 3'h3;
    localparam logic [2:0]  MPSC_C4 = 3'h4;

    // Number of DRAM channels
    localparam int          MPSC_NCH = 2;

    // Request channel toward the I/O hub
    typedef enum logic [0:0] {
        MPSC_REQ_IDLE,
        MPSC_REQ_SEND
    } mpsc_req_state_t;

endpackage

// File: rtl/mpsc_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module mpsc_sync (
    input  wire logic clk_sys_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_reg;
    logic sync_reg;

    // No reset: power-good must pass even while warm reset is held
    always_ff @(posedge clk_sys_i) begin
        meta_reg <= async_i;
        sync_reg <= meta_reg;
    end

    assign sync_o = sync_reg;
endmodule

// File: rtl/mpsc_sr_bit.sv
// One self-refresh status bit, reset only by loss of power-good; also cleared by hardware exit or software write
`timescale 1ns/100ps
module mpsc_sr_bit (
    input  wire logic clk_sys_i,
    input  wire logic pg_i,
    input  wire logic set_i,
    input  wire logic hw_clr_i,
    input  wire logic sw_clr_i,
    output logic      bit_o
);
    logic bit_reg;
    logic bit_next;

    // Set wins over both clears so an entry is never lost
    assign bit_next = set_i ? 1'b1 : ((hw_clr_i | sw_clr_i) ? 1'b0 : bit_reg);

    // Warm reset does not reach this flop
    always_ff @(posedge clk_sys_i) begin
        if (!pg_i) begin
            bit_reg <= mpsc_pkg::MPSC_RST_SRSTAT[0];
        end else begin
            bit_reg <= bit_next;
        end
    end

    assign bit_o = bit_reg;
endmodule

// File: rtl/mpsc_top.sv
// Memory power state control: DLL gating, PM config and self-refresh status
`timescale 1ns/100ps
module mpsc_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        pwr_good_i,
    input  wire logic [11:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    input  wire logic [2:0]  cpu_cstate_i,
    input  wire logic        dll_cond_ok_i,
    output logic             dll_pd_allow_o,
    input  wire logic        snoop_i,
    input  wire logic        pm_req_valid_i,
    input  wire logic [2:0]  pm_req_cstate_i,
    output logic             hub_req_valid_o,
    output logic      [2:0]  hub_req_cstate_o,
    input  wire logic        hub_req_ack_i,
    input  wire logic [1:0]  sr_entered_i,
    input  wire logic [1:0]  sr_exit_req_i,
    output logic      [1:0]  sr_exit_go_o,
    output logic      [1:0]  sr_status_o
);

    logic                    pg_sync;
    logic                    cold_rst;
    logic [15:0]             dllpd_reg;
    logic [15:0]             dllpd_next;
    logic [31:0]             power_management_configuration_reg;
    logic [31:0]             power_management_configuration_next;
    wire  [1:0]              srstat;
    wire  [1:0]              sw_clr;
    wire  [1:0]              hw_clr;
    logic [1:0]              exit_go_reg;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic                    rvalid_reg;
    logic                    dll_allow_reg;
    logic                    dll_allow_next;
    mpsc_pkg::mpsc_req_state_t state_reg;
    mpsc_pkg::mpsc_req_state_t state_next;
    logic                    snoop_pend_reg;
    logic                    snoop_pend_next;
    logic                    req_valid_reg;
    logic [2:0]              req_cstate_reg;
    logic [2:0]              req_cstate_next;

    wire  [2:0]  dep_field;
    wire         enh_en;
    wire         snoop_c0;
    wire  [1:0]  mode_field;
    wire         hit_dllpd;
    wire         hit_power_management_configuration;
    wire         hit_srstat;
    wire         wr_dllpd;
    wire         wr_power_management_configuration;
    wire         wr_srstat;
    wire         cstate_deep;
    wire         dep_ok;
    wire  [2:0]  snoop_code;
    wire  [2:0]  limit_code;
    wire  [2:0]  clamp_code;
    wire         idle;
    wire         load_snoop;
    wire         load_pm;

    // Power-good arrives from a pin
    mpsc_sync u_pg_sync (
        .clk_sys_i (clk_sys_i),
        .async_i   (pwr_good_i),
        .sync_o    (pg_sync)
    );

    // Control registers also fall back on loss of power
    assign cold_rst = rst_i | ~pg_sync;

    // Address decode
    assign hit_dllpd  = (reg_addr_i == mpsc_pkg::MPSC_OFF_DLLPD);
    assign hit_power_management_configuration  = (reg_addr_i == mpsc_pkg::MPSC_OFF_POWER_MANAGEMENT_CONFIGURATION);
    assign hit_srstat = (reg_addr_i == mpsc_pkg::MPSC_OFF_SRSTAT);
    assign wr_dllpd   = reg_wr_i & hit_dllpd;
    assign wr_power_management_configuration   = reg_wr_i & hit_power_management_configuration;
    assign wr_srstat  = reg_wr_i & hit_srstat;

    // Field extraction
    assign dep_field  = dllpd_reg[mpsc_pkg::MPSC_DEP_MSB:mpsc_pkg::MPSC_DEP_LSB];
    assign enh_en     = power_management_configuration_reg[mpsc_pkg::MPSC_EN_BIT];
    assign snoop_c0   = power_management_configuration_reg[mpsc_pkg::MPSC_SNOOP_BIT];
    assign mode_field = power_management_configuration_reg[mpsc_pkg::MPSC_MODE_MSB:mpsc_pkg::MPSC_MODE_LSB];

    // Register next values; reserved read-only bits stay zero
    assign dllpd_next = wr_dllpd ? (reg_wdata_i[15:0] & mpsc_pkg::MPSC_WMASK_DLLPD) : dllpd_reg;
    assign power_management_configuration_next = wr_power_management_configuration ? (reg_wdata_i & mpsc_pkg::MPSC_WMASK_POWER_MANAGEMENT_CONFIGURATION) : power_management_configuration_reg;

    // Configuration storage
    always_ff @(posedge clk_sys_i) begin
        if (cold_rst) begin
            dllpd_reg <= mpsc_pkg::MPSC_RST_DLLPD;
            power_management_configuration_reg <= mpsc_pkg::MPSC_RST_POWER_MANAGEMENT_CONFIGURATION;
        end else begin
            dllpd_reg <= dllpd_next;
            power_management_configuration_reg <= power_management_configuration_next;
        end
    end

    // DLL power-down gate: only code 110 with the CPU in C3 or C4
    assign cstate_deep    = (cpu_cstate_i == mpsc_pkg::MPSC_C3) | (cpu_cstate_i == mpsc_pkg::MPSC_C4);
    assign dep_ok         = (dep_field == mpsc_pkg::MPSC_DEP_C3C4) & cstate_deep;
    assign dll_allow_next = dep_ok & dll_cond_ok_i;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dll_allow_reg <= 1'b0;
        end else begin
            dll_allow_reg <= dll_allow_next;
        end
    end

    // Snoop maps to C2 normally, C0 when the behaviour bit is set
    assign snoop_code = snoop_c0 ? mpsc_pkg::MPSC_C0 : mpsc_pkg::MPSC_C2;

    // Deepest state the mode allows; reserved 11 treated as no limit
    assign limit_code = (mode_field == mpsc_pkg::MPSC_MODE_C2) ? mpsc_pkg::MPSC_C2 :
                        (mode_field == mpsc_pkg::MPSC_MODE_C3) ? mpsc_pkg::MPSC_C3 :
                        mpsc_pkg::MPSC_C4;

    // Legacy mode passes requests unchanged
    assign clamp_code = (enh_en && (pm_req_cstate_i > limit_code)) ? limit_code : pm_req_cstate_i;

    // A pending snoop goes first so the hub is woken quickly
    assign idle       = (state_reg == mpsc_pkg::MPSC_REQ_IDLE);
    assign load_snoop = idle & snoop_pend_reg;
    assign load_pm    = idle & ~snoop_pend_reg & pm_req_valid_i;

    // Snoops are only reported in enhanced mode; held until served
    assign snoop_pend_next = (snoop_i & enh_en) | (snoop_pend_reg & ~load_snoop);

    // Request channel state machine
    always_comb begin
        state_next      = state_reg;
        req_cstate_next = req_cstate_reg;
        case (state_reg)
            mpsc_pkg::MPSC_REQ_IDLE: begin
                if (load_snoop) begin
                    req_cstate_next = snoop_code;
                    state_next      = mpsc_pkg::MPSC_REQ_SEND;
                end else if (load_pm) begin
                    req_cstate_next = clamp_code;
                    state_next      = mpsc_pkg::MPSC_REQ_SEND;
                end
            end
            mpsc_pkg::MPSC_REQ_SEND: begin
                if (hub_req_ack_i) begin
                    state_next = mpsc_pkg::MPSC_REQ_IDLE;
                end
            end
            default: begin
                state_next = mpsc_pkg::MPSC_REQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg      <= mpsc_pkg::MPSC_REQ_IDLE;
            snoop_pend_reg <= 1'b0;
            req_valid_reg  <= 1'b0;
            req_cstate_reg <= mpsc_pkg::MPSC_C0;
        end else begin
            state_reg      <= state_next;
            snoop_pend_reg <= snoop_pend_next;
            req_valid_reg  <= (state_next == mpsc_pkg::MPSC_REQ_SEND);
            req_cstate_reg <= req_cstate_next;
        end
    end

    // Per-channel self-refresh status
    generate
        for (genvar ch = 0; ch < mpsc_pkg::MPSC_NCH; ch++) begin : g_ch
            assign sw_clr[ch] = wr_srstat & reg_wdata_i[ch];
            assign hw_clr[ch] = sr_exit_req_i[ch];

            mpsc_sr_bit u_bit (
                .clk_sys_i (clk_sys_i),
                .pg_i      (pg_sync),
                .set_i     (sr_entered_i[ch]),
                .hw_clr_i  (hw_clr[ch]),
                .sw_clr_i  (sw_clr[ch]),
                .bit_o     (srstat[ch])
            );
        end
    endgenerate

    // Exit go follows the clear so the bit is already low at exit start
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            exit_go_reg <= 2'h0;
        end else begin
            exit_go_reg <= sr_exit_req_i;
        end
    end

    // Read mux; unmapped addresses read zero
    assign rdata_next = hit_dllpd  ? {16'h0000, dllpd_reg} :
                        hit_power_management_configuration  ? power_management_configuration_reg :
                        hit_srstat ? {30'h0, srstat} :
                        32'h00000000;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_reg  <= 32'h00000000;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= reg_rd_i ? rdata_next : rdata_reg;
            rvalid_reg <= reg_rd_i;
        end
    end

    assign reg_rdata_o      = rdata_reg;
    assign reg_rvalid_o     = rvalid_reg;
    assign dll_pd_allow_o   = dll_allow_reg;
    assign hub_req_valid_o  = req_valid_reg;
    assign hub_req_cstate_o = req_cstate_reg;
    assign sr_exit_go_o     = exit_go_reg;
    assign sr_status_o      = srstat;

    // Checks on the outputs this block drives
    property p_dll_never;
        @(posedge clk_sys_i) disable iff (rst_i)
        (dep_field != mpsc_pkg::MPSC_DEP_C3C4) |=> !dll_pd_allow_o;
    endproperty
    a_dll_never: assert property (p_dll_never) else $error("DLL power-down allowed with forbidding code");

    property p_dll_allow;
        @(posedge clk_sys_i) disable iff (rst_i)
        (dep_field == mpsc_pkg::MPSC_DEP_C3C4) && dll_cond_ok_i &&
        (cpu_cstate_i == mpsc_pkg::MPSC_C4) |=> dll_pd_allow_o;
    endproperty
    a_dll_allow: assert property (p_dll_allow) else $error("DLL power-down not allowed in C4");

    property p_dll_cond;
        @(posedge clk_sys_i) disable iff (rst_i)
        !dll_cond_ok_i |=> !dll_pd_allow_o;
    endproperty
    a_dll_cond: assert property (p_dll_cond) else $error("DLL power-down without other conditions");

    property p_legacy_no_snoop;
        @(posedge clk_sys_i) disable iff (rst_i)
        idle && !snoop_pend_reg && !enh_en && !pm_req_valid_i |=> !hub_req_valid_o && !snoop_pend_reg;
    endproperty
    a_legacy_no_snoop: assert property (p_legacy_no_snoop) else $error("Hub request in legacy idle");

    property p_snoop_code;
        @(posedge clk_sys_i) disable iff (rst_i)
        load_snoop |=> hub_req_valid_o && (hub_req_cstate_o == ($past(snoop_c0) ? 3'h0 : 3'h2));
    endproperty
    a_snoop_code: assert property (p_snoop_code) else $error("Wrong snoop C-state request");

    property p_mode_c2;
        @(posedge clk_sys_i) disable iff (rst_i)
        load_pm && enh_en && (mode_field == mpsc_pkg::MPSC_MODE_C2) |=> hub_req_cstate_o <= 3'h2;
    endproperty
    a_mode_c2: assert property (p_mode_c2) else $error("Request deeper than C2");

    property p_legacy_pass;
        @(posedge clk_sys_i) disable iff (rst_i)
        load_pm && !enh_en |=> hub_req_cstate_o == $past(pm_req_cstate_i);
    endproperty
    a_legacy_pass: assert property (p_legacy_pass) else $error("Legacy request altered");

    property p_pg_clear;
        @(posedge clk_sys_i) !pg_sync |=> (sr_status_o == 2'h0);
    endproperty
    a_pg_clear: assert property (p_pg_clear) else $error("Status not cleared by power-good");

    property p_warm_keep;
        @(posedge clk_sys_i) rst_i && pg_sync && (sr_entered_i == 2'h0) &&
        (sr_exit_req_i == 2'h0) && !wr_srstat |=> $stable(sr_status_o);
    endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("Warm reset changed status");

    property p_set0;
        @(posedge clk_sys_i) pg_sync && sr_entered_i[0] |=> sr_status_o[0];
    endproperty
    a_set0: assert property (p_set0) else $error("Channel 0 status not set");

    property p_set1;
        @(posedge clk_sys_i) pg_sync && sr_entered_i[1] |=> sr_status_o[1];
    endproperty
    a_set1: assert property (p_set1) else $error("Channel 1 status not set");

    property p_exit_order;
        @(posedge clk_sys_i) disable iff (rst_i)
        sr_exit_req_i[0] && !sr_entered_i[0] |=> sr_exit_go_o[0] && !sr_status_o[0];
    endproperty
    a_exit_order: assert property (p_exit_order) else $error("Exit began with status set");

    property p_w1c;
        @(posedge clk_sys_i) wr_srstat && reg_wdata_i[1] && !sr_entered_i[1] |=> !sr_status_o[1];
    endproperty
    a_w1c: assert property (p_w1c) else $error("Write one did not clear status");

    c_dll_allowed: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(dll_pd_allow_o));
    c_snoop_req: cover property (@(posedge clk_sys_i) disable iff (rst_i) load_snoop ##1 hub_req_ack_i);
    c_sr_cycle: cover property (@(posedge clk_sys_i) sr_status_o[0] ##1 sr_exit_go_o[0]);
    c_w1c: cover property (@(posedge clk_sys_i) sr_status_o[1] && wr_srstat && reg_wdata_i[1]);

endmodule

// File: verif/mpsc_hub_model.sv
// Companion I/O hub model that accepts C-state requests with a settable delay
`timescale 1ns/100ps
module mpsc_hub_model (
    input  wire logic       clk_sys_i,
    input  wire logic       req_valid_i,
    input  wire logic [2:0] req_cstate_i,
    input  wire logic [3:0] delay_i,
    output logic            ack_o,
    output logic      [2:0] last_cstate_o,
    output int              acks_o
);
    logic [3:0] wait_cnt;

    initial begin
        ack_o = 1'b0;
        last_cstate_o = 3'h7;
        acks_o = 0;
        wait_cnt = 4'h0;
    end

    // Ack moves off the sampling edge; the delay lets the hub answer slowly
    always @(negedge clk_sys_i) begin
        if (ack_o) begin
            ack_o <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (req_valid_i) begin
            if (wait_cnt >= delay_i) begin
                ack_o <= 1'b1;
                last_cstate_o <= req_cstate_i;
                acks_o <= acks_o + 1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// File: verif/mpsc_tb.sv
// Self-checking testbench for the memory power state control block
`timescale 1ns/100ps
module mpsc_tb;
    localparam logic [11:0] A_DLL = mpsc_pkg::MPSC_OFF_DLLPD;
    localparam logic [11:0] A_CFG = mpsc_pkg::MPSC_OFF_POWER_MANAGEMENT_CONFIGURATION;
    localparam logic [11:0] A_SR  = mpsc_pkg::MPSC_OFF_SRSTAT;

    logic        clk_sys_i;
    logic        rst_i;
    logic        pwr_good_i;
    logic [11:0] reg_addr_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_wdata_i;
    logic [31:0] reg_rdata_o;
    logic        reg_rvalid_o;
    logic [2:0]  cpu_cstate_i;
    logic        dll_cond_ok_i;
    logic        dll_pd_allow_o;
    logic        snoop_i;
    logic        pm_req_valid_i;
    logic [2:0]  pm_req_cstate_i;
    logic        hub_req_valid_o;
    logic [2:0]  hub_req_cstate_o;
    logic        hub_req_ack_i;
    logic [1:0]  sr_entered_i;
    logic [1:0]  sr_exit_req_i;
    logic [1:0]  sr_exit_go_o;
    logic [1:0]  sr_status_o;
    logic [3:0]  hub_delay;
    logic [2:0]  hub_cs;
    int          hub_acks;
    int          fails;
    int          n_compared;

    mpsc_top dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pwr_good_i(pwr_good_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .cpu_cstate_i(cpu_cstate_i), .dll_cond_ok_i(dll_cond_ok_i),
        .dll_pd_allow_o(dll_pd_allow_o), .snoop_i(snoop_i), .pm_req_valid_i(pm_req_valid_i),
        .pm_req_cstate_i(pm_req_cstate_i), .hub_req_valid_o(hub_req_valid_o),
        .hub_req_cstate_o(hub_req_cstate_o), .hub_req_ack_i(hub_req_ack_i), .sr_entered_i(sr_entered_i),
        .sr_exit_req_i(sr_exit_req_i), .sr_exit_go_o(sr_exit_go_o), .sr_status_o(sr_status_o)
    );

    mpsc_hub_model hub (
        .clk_sys_i(clk_sys_i), .req_valid_i(hub_req_valid_o), .req_cstate_i(hub_req_cstate_o),
        .delay_i(hub_delay), .ack_o(hub_req_ack_i), .last_cstate_o(hub_cs), .acks_o(hub_acks)
    );

    // 250 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk_sys_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask

    // Read data is judged in the cycle its valid pulse stands
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(negedge clk_sys_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clk_sys_i);
        chk("read valid", 32'h1, {31'h0, reg_rvalid_o});
        chk(what, exp, reg_rdata_o);
        reg_rd_i = 1'b0;
    endtask

    // Snoop is a pulse; a PM request is held high until the hub has served it
    task automatic req(input logic snp, input logic [2:0] cs, input logic [2:0] exp);
        int n0;
        int k;
        n0 = hub_acks;
        @(negedge clk_sys_i);
        snoop_i = snp;
        pm_req_valid_i = ~snp;
        pm_req_cstate_i = cs;
        k = 0;
        while (hub_acks == n0 && k < 40) begin
            @(negedge clk_sys_i);
            snoop_i = 1'b0;
            k++;
        end
        pm_req_valid_i = 1'b0;
        chk("hub ack count", n0 + 1, hub_acks);
        chk("hub cstate", {29'h0, exp}, {29'h0, hub_cs});
        chk("hub valid drop", 32'h0, {31'h0, hub_req_valid_o});
    endtask

    task automatic sr_pulse(input logic [1:0] ent, input logic [1:0] ext);
        @(negedge clk_sys_i);
        sr_entered_i = ent;
        sr_exit_req_i = ext;
        @(negedge clk_sys_i);
        sr_entered_i = 2'h0;
        sr_exit_req_i = 2'h0;
    endtask

    // Reset values, write masks and an unmapped place
    task automatic t_regs;
        rd_chk(A_DLL, 32'h00000000, "dll ctl reset");
        rd_chk(A_CFG, 32'h00000000, "pm cfg reset");
        rd_chk(A_SR, 32'h00000000, "sr status reset");
        wr(A_DLL, 32'hFFFFFFFF);
        rd_chk(A_DLL, 32'h0000607F, "dll ctl mask");
        wr(A_CFG, 32'hFFFFFFFF);
        rd_chk(A_CFG, 32'hC000001F, "pm cfg mask");
        wr(12'h100, 32'hFFFFFFFF);
        rd_chk(12'h100, 32'h00000000, "unmapped read");
        rd_chk(A_CFG, 32'hC000001F, "pm cfg kept");
        wr(A_CFG, 32'h00000000);
    endtask

    // Every dependency code against every C state, with and without other conditions
    task automatic t_dll;
        logic exp;
        for (int dep = 0; dep < 8; dep++) begin
            wr(A_DLL, 32'(dep) << mpsc_pkg::MPSC_DEP_LSB);
            for (int cs = 0; cs < 5; cs++) begin
                for (int ok = 0; ok < 2; ok++) begin
                    @(negedge clk_sys_i);
                    cpu_cstate_i = 3'(cs);
                    dll_cond_ok_i = ok[0];
                    exp = (dep == 6) && (cs == 3 || cs == 4) && (ok == 1);
                    @(negedge clk_sys_i);
                    chk("dll allow", {31'h0, exp}, {31'h0, dll_pd_allow_o});
                end
            end
        end
        dll_cond_ok_i = 1'b0;
    endtask

    // Legacy and enhanced request paths, with a slow hub in between
    task automatic t_hub;
        int n0;
        wr(A_CFG, 32'h00000001);
        req(1'b0, 3'h4, 3'h4);
        n0 = hub_acks;
        @(negedge clk_sys_i);
        snoop_i = 1'b1;
        @(negedge clk_sys_i);
        snoop_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        chk("legacy snoop", n0, hub_acks);
        wr(A_CFG, 32'h00000010);
        req(1'b1, 3'h0, 3'h2);
        req(1'b0, 3'h4, 3'h4);
        wr(A_CFG, 32'h00000018);
        req(1'b1, 3'h0, 3'h0);
        wr(A_CFG, 32'h00000011);
        hub_delay = 4'h4;
        req(1'b0, 3'h4, 3'h2);
        hub_delay = 4'h0;
        wr(A_CFG, 32'h00000012);
        req(1'b0, 3'h4, 3'h3);
        req(1'b0, 3'h2, 3'h2);
        wr(A_CFG, 32'h00000013);
        req(1'b0, 3'h4, 3'h4);
    endtask

    // Status set, kept over warm reset, cleared by software, exit and power loss
    task automatic t_sr;
        sr_pulse(2'h1, 2'h0);
        chk("sr status", 32'h1, {30'h0, sr_status_o});
        sr_pulse(2'h2, 2'h0);
        rd_chk(A_SR, 32'h00000003, "sr status read");
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk("sr after warm reset", 32'h3, {30'h0, sr_status_o});
        rd_chk(A_CFG, 32'h00000000, "pm cfg after reset");
        wr(A_SR, 32'h00000001);
        chk("sr after w1c", 32'h2, {30'h0, sr_status_o});
        sr_pulse(2'h0, 2'h2);
        chk("sr before exit", 32'h0, {30'h0, sr_status_o});
        chk("exit go", 32'h2, {30'h0, sr_exit_go_o});
        @(negedge clk_sys_i);
        chk("exit go end", 32'h0, {30'h0, sr_exit_go_o});
        sr_pulse(2'h3, 2'h0);
        wr(A_SR, 32'h00000002);
        chk("sr after w1c ch1", 32'h1, {30'h0, sr_status_o});
        sr_pulse(2'h0, 2'h1);
        chk("sr before exit ch0", 32'h0, {30'h0, sr_status_o});
        chk("exit go ch0", 32'h1, {30'h0, sr_exit_go_o});
        sr_pulse(2'h3, 2'h0);
        chk("sr before pg loss", 32'h3, {30'h0, sr_status_o});
        pwr_good_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk("sr after pg loss", 32'h0, {30'h0, sr_status_o});
        pwr_good_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask

    task automatic summarize;
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence: power-good low during reset so status starts known
    initial begin
        fails = 0;
        n_compared = 0;
        rst_i = 1'b1;
        pwr_good_i = 1'b0;
        reg_addr_i = 12'h000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 32'h00000000;
        cpu_cstate_i = 3'h0;
        dll_cond_ok_i = 1'b0;
        snoop_i = 1'b0;
        pm_req_valid_i = 1'b0;
        pm_req_cstate_i = 3'h0;
        sr_entered_i = 2'h0;
        sr_exit_req_i = 2'h0;
        hub_delay = 4'h0;
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        pwr_good_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        t_regs();
        t_dll();
        t_hub();
        t_sr();
        summarize();
    end

    // Watchdog well beyond the roughly three hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        summarize();
    end
endmodule
